/* mid_map.svh */
`ifndef MID_MAP_SVH
`define MID_MAP_SVH

// ****************************************************************************
// widths and reset values
// ****************************************************************************
`define MID_PC_W          15
`define MID_INSTR_W       14
`define MID_PTR_W         16
`define MID_STACK_DEPTH   16
`define MID_PC_RST        15'h0000
`define MID_W_RST         8'h00
`define MID_OPTION_RST    8'hFF
`define MID_DIR_RST       8'hFF
`define MID_PTR_RST       16'h0000

// ****************************************************************************
// exact opcodes
// ****************************************************************************
`define MID_OP_NOP        14'h0000
`define MID_OP_SOFT_RST   14'h0001
`define MID_OP_RETURN     14'h0008
`define MID_OP_INT_EXIT   14'h0009
`define MID_OP_CALL_ACC   14'h000A
`define MID_OP_BRANCH_ACC 14'h000B
`define MID_OP_OPTION     14'h0062
`define MID_OP_STANDBY    14'h0063
`define MID_OP_WD_CLEAR   14'h0064

// ****************************************************************************
// opcode patterns and masks
// ****************************************************************************
`define MID_PAT_DIR_LOAD  14'h0060
`define MID_MSK_DIR_LOAD  14'h3FF8
`define MID_PAT_LD_MOD    14'h0010
`define MID_PAT_ST_MOD    14'h0018
`define MID_MSK_MOD       14'h3FF8
`define MID_PAT_RET_LIT   14'h3400
`define MID_MSK_RET_LIT   14'h3F00
`define MID_PAT_PTR_ADD   14'h3100
`define MID_PAT_LD_IDX    14'h3F00
`define MID_PAT_ST_IDX    14'h3F80
`define MID_MSK_K6        14'h3F80
`define MID_PAT_ROT_R     14'h0C00
`define MID_MSK_ROT_R     14'h3F00

// ****************************************************************************
// field positions
// ****************************************************************************
`define MID_F_PTR_SEL     6
`define MID_F_MOD_SEL     2
`define MID_F_DEST        7
`define MID_F_WIN_BIT     15

`endif

/* mid_pkg.sv */
`include "mid_map.svh"

package mid_pkg;

  typedef enum logic [1:0] {
    MID_ST_EXEC    = 2'b00,
    MID_ST_FLUSH   = 2'b01,
    MID_ST_EXTRA   = 2'b10,
    MID_ST_STANDBY = 2'b11
  } mid_state_e;

  typedef enum logic [1:0] {
    MID_MOD_PRE_INC  = 2'b00,
    MID_MOD_PRE_DEC  = 2'b01,
    MID_MOD_POST_INC = 2'b10,
    MID_MOD_POST_DEC = 2'b11
  } mid_mod_e;

  typedef struct packed {
    logic carry;
    logic zero;
    logic timeout_flag;
    logic powerdown_flag;
  } mid_flags_s;

  typedef struct packed {
    logic [`MID_PTR_W-1:0] addr;
    logic [7:0]            wdata;
    logic                  we;
  } mid_dmem_s;

endpackage

/* mid_stack.sv */
`timescale 1ns/1ns
`default_nettype none
`include "mid_map.svh"

module mid_stack
  import mid_pkg::*;
#(
  parameter int DEPTH = `MID_STACK_DEPTH
)(
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 srst,
  // stack access
  input  wire logic                 push,
  input  wire logic                 pop,
  input  wire logic [`MID_PC_W-1:0] push_data,
  output logic      [`MID_PC_W-1:0] stack_top_entry,
  output logic                      overflow,
  output logic                      underflow
);

  localparam int PW = $clog2(DEPTH) + 1;

  // depth outside what the counter and index slice can serve
  if (DEPTH < 2 || DEPTH > 64)
  begin
    $error("mid_stack: DEPTH out of range");
  end

  typedef struct packed {
    logic [DEPTH-1:0][`MID_PC_W-1:0] mem;
    logic [PW-1:0]                   cnt;
    logic                            ovf;
    logic                            unf;
  } mid_stack_s;

  mid_stack_s stk_r;
  mid_stack_s stk_nxt;

  always_comb
  begin
    stk_nxt = stk_r;
    if (push)
    begin
      if (stk_r.cnt == PW'(DEPTH))
        stk_nxt.ovf = 1'b1;
      else
      begin
        stk_nxt.mem[stk_r.cnt[PW-2:0]] = push_data;
        stk_nxt.cnt = stk_r.cnt + PW'(1);
      end
    end
    else if (pop)
    begin
      if (stk_r.cnt == '0)
        stk_nxt.unf = 1'b1;
      else
        stk_nxt.cnt = stk_r.cnt - PW'(1);
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      stk_r <= '0;
    else
      stk_r <= stk_nxt;
  end

  logic [PW-1:0] top_idx;
  assign top_idx         = stk_r.cnt - PW'(1);
  assign stack_top_entry = (stk_r.cnt == '0) ? '0 : stk_r.mem[top_idx[PW-2:0]];
  assign overflow        = stk_r.ovf;
  assign underflow       = stk_r.unf;

endmodule

`default_nettype wire

/* mid_ptr.sv */
`timescale 1ns/1ns
`default_nettype none
`include "mid_map.svh"

module mid_ptr
  import mid_pkg::*;
(
  // pointer in
  input  wire logic [`MID_PTR_W-1:0] ptr,
  input  wire logic [1:0]            mod_sel,
  input  wire logic [5:0]            k6,
  input  wire logic                  indexed,
  // results
  output logic      [`MID_PTR_W-1:0] eff_addr,
  output logic      [`MID_PTR_W-1:0] ptr_new,
  output logic      [`MID_PTR_W-1:0] ptr_plus_k
);

  function automatic logic [`MID_PTR_W-1:0] sext6(input logic [5:0] k);
    sext6 = {{(`MID_PTR_W-6){k[5]}}, k};
  endfunction

  logic [`MID_PTR_W-1:0] inc;
  logic [`MID_PTR_W-1:0] dec;

  assign inc        = ptr + `MID_PTR_W'(1);
  assign dec        = ptr - `MID_PTR_W'(1);
  assign ptr_plus_k = ptr + sext6(k6);

  always_comb
  begin
    eff_addr = ptr_plus_k;
    ptr_new  = ptr;
    if (!indexed)
    begin
      unique case (mid_mod_e'(mod_sel))
        MID_MOD_PRE_INC:
        begin
          eff_addr = inc;
          ptr_new  = inc;
        end
        MID_MOD_PRE_DEC:
        begin
          eff_addr = dec;
          ptr_new  = dec;
        end
        MID_MOD_POST_INC:
        begin
          eff_addr = ptr;
          ptr_new  = inc;
        end
        MID_MOD_POST_DEC:
        begin
          eff_addr = ptr;
          ptr_new  = dec;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

/* mid_core.sv */
`timescale 1ns/1ns
`default_nettype none
`include "mid_map.svh"

module mid_core
  import mid_pkg::*;
#(
  parameter int STACK_DEPTH = `MID_STACK_DEPTH,
  parameter int DIR_REGS    = 8
)(
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    srst,
  // program memory
  output logic      [`MID_PC_W-1:0]    prog_addr,
  input  wire logic [`MID_INSTR_W-1:0] prog_data,
  // data memory
  output mid_dmem_s                    dmem,
  input  wire logic [7:0]              dmem_rdata,
  // standby and watchdog
  input  wire logic                    wake,
  output logic                         osc_stop,
  output logic                         wdt_clear,
  output logic                         soft_reset,
  // visible state
  output logic      [7:0]              acc,
  output mid_flags_s                   flags,
  output logic      [7:0]              option_reg,
  output logic      [DIR_REGS-1:0][7:0] pin_dir,
  output logic                         int_enable,
  output logic                         stack_overflow,
  output logic                         stack_underflow
);

  // opcode selects one of exactly eight direction registers
  if (DIR_REGS != 8)
  begin
    $error("mid_core: DIR_REGS must be 8");
  end

  // ****************************************************************************
  // state
  // ****************************************************************************
  typedef struct packed {
    mid_state_e                          st;
    logic [`MID_PC_W-1:0]                pc;
    logic [7:0]                          w;
    logic [7:0]                          option;
    logic [DIR_REGS-1:0][7:0]            dir;
    logic [1:0][`MID_PTR_W-1:0]          ptr;
    mid_flags_s                          fl;
    logic                                wdt_clr;
    logic                                sw_rst;
    logic                                gie;
  } mid_core_s;

  mid_core_s cs_r;
  mid_core_s cs_nxt;

  function automatic logic op_is(input logic [`MID_INSTR_W-1:0] i,
                                 input logic [`MID_INSTR_W-1:0] pat,
                                 input logic [`MID_INSTR_W-1:0] msk);
    op_is = ((i & msk) == pat);
  endfunction

  function automatic mid_core_s reset_state();
    mid_core_s s;
    s         = '0;
    s.st      = MID_ST_EXEC;
    s.pc      = `MID_PC_RST;
    s.w       = `MID_W_RST;
    s.option  = `MID_OPTION_RST;
    s.dir     = {DIR_REGS{`MID_DIR_RST}};
    s.ptr     = {2{`MID_PTR_RST}};
    s.fl.timeout_flag   = 1'b1;
    s.fl.powerdown_flag = 1'b1;
    reset_state = s;
  endfunction

  // ****************************************************************************
  // decode
  // ****************************************************************************
  logic [`MID_INSTR_W-1:0] ir;
  logic                    dec_ld_mod;
  logic                    dec_st_mod;
  logic                    dec_ld_idx;
  logic                    dec_st_idx;
  logic                    dec_ind;
  logic                    dec_ptr_add;
  logic                    dec_ret_lit;
  logic                    dec_rot;
  logic                    dec_dir_load;
  logic                    psel;
  logic                    idx;
  logic [`MID_PTR_W-1:0]   ptr_cur;

  assign ir           = prog_data;
  assign dec_ld_mod   = op_is(ir, `MID_PAT_LD_MOD, `MID_MSK_MOD);
  assign dec_st_mod   = op_is(ir, `MID_PAT_ST_MOD, `MID_MSK_MOD);
  assign dec_ld_idx   = op_is(ir, `MID_PAT_LD_IDX, `MID_MSK_K6);
  assign dec_st_idx   = op_is(ir, `MID_PAT_ST_IDX, `MID_MSK_K6);
  assign dec_ptr_add  = op_is(ir, `MID_PAT_PTR_ADD, `MID_MSK_K6);
  assign dec_ret_lit  = op_is(ir, `MID_PAT_RET_LIT, `MID_MSK_RET_LIT);
  assign dec_rot      = op_is(ir, `MID_PAT_ROT_R, `MID_MSK_ROT_R);
  assign dec_dir_load = op_is(ir, `MID_PAT_DIR_LOAD, `MID_MSK_DIR_LOAD);
  assign dec_ind      = dec_ld_mod | dec_st_mod | dec_ld_idx | dec_st_idx;
  assign idx          = dec_ld_idx | dec_st_idx;
  // indexed forms and pointer add carry n in bit 6, modifier forms in bit 2
  assign psel         = (idx || dec_ptr_add) ? ir[`MID_F_PTR_SEL] : ir[`MID_F_MOD_SEL];
  assign ptr_cur      = cs_r.ptr[psel];

  // ****************************************************************************
  // pointer arithmetic and return stack
  // ****************************************************************************
  logic [`MID_PTR_W-1:0] eff_addr;
  logic [`MID_PTR_W-1:0] ptr_new;
  logic [`MID_PTR_W-1:0] ptr_plus_k;

  mid_ptr u_ptr (
    .ptr        (ptr_cur),
    .mod_sel    (ir[1:0]),
    .k6         (ir[5:0]),
    .indexed    (idx),
    .eff_addr   (eff_addr),
    .ptr_new    (ptr_new),
    .ptr_plus_k (ptr_plus_k)
  );

  logic                 push;
  logic                 pop;
  logic [`MID_PC_W-1:0] stack_top_entry;

  mid_stack #(
    .DEPTH (STACK_DEPTH)
  ) u_stack (
    .clk             (clk),
    .srst            (srst),
    .push            (push),
    .pop             (pop),
    .push_data       (cs_r.pc + `MID_PC_W'(1)),
    .stack_top_entry (stack_top_entry),
    .overflow        (stack_overflow),
    .underflow       (stack_underflow)
  );

  // ****************************************************************************
  // execute
  // ****************************************************************************
  logic                 run;
  logic                 slow;
  logic [`MID_PC_W-1:0] pc_inc;
  logic [7:0]           rot_res;

  assign pc_inc  = cs_r.pc + `MID_PC_W'(1);
  assign slow    = dec_ind && ptr_cur[`MID_F_WIN_BIT];
  assign rot_res = {cs_r.fl.carry, dmem_rdata[7:1]};

  always_comb
  begin
    cs_nxt         = cs_r;
    cs_nxt.wdt_clr = 1'b0;
    cs_nxt.sw_rst  = 1'b0;
    push           = 1'b0;
    pop            = 1'b0;
    dmem           = '0;
    run            = 1'b0;
    unique case (cs_r.st)
      MID_ST_FLUSH:
        cs_nxt.st = MID_ST_EXEC;
      MID_ST_STANDBY:
      begin
        if (wake)
        begin
          cs_nxt.st = MID_ST_EXEC;
          cs_nxt.pc = pc_inc;
        end
      end
      MID_ST_EXTRA:
        run = 1'b1;
      MID_ST_EXEC:
      begin
        if (slow)
          cs_nxt.st = MID_ST_EXTRA;
        else
          run = 1'b1;
      end
    endcase

    // no memory write or stack move while reset is held
    if (run && !srst)
    begin
      cs_nxt.st = MID_ST_EXEC;
      cs_nxt.pc = pc_inc;
      if (ir == `MID_OP_BRANCH_ACC)
      begin
        cs_nxt.pc = pc_inc + {{(`MID_PC_W-8){1'b0}}, cs_r.w};
        cs_nxt.st = MID_ST_FLUSH;
      end
      else if (ir == `MID_OP_CALL_ACC)
      begin
        push      = 1'b1;
        cs_nxt.pc = {cs_r.pc[`MID_PC_W-1:8], cs_r.w};
        cs_nxt.st = MID_ST_FLUSH;
      end
      else if (ir == `MID_OP_INT_EXIT)
      begin
        pop        = 1'b1;
        cs_nxt.pc  = stack_top_entry;
        cs_nxt.gie = 1'b1;
        cs_nxt.st  = MID_ST_FLUSH;
      end
      else if (ir == `MID_OP_RETURN)
      begin
        pop       = 1'b1;
        cs_nxt.pc = stack_top_entry;
        cs_nxt.st = MID_ST_FLUSH;
      end
      else if (dec_ret_lit)
      begin
        pop       = 1'b1;
        cs_nxt.w  = ir[7:0];
        cs_nxt.pc = stack_top_entry;
        cs_nxt.st = MID_ST_FLUSH;
      end
      else if (ir == `MID_OP_SOFT_RST)
      begin
        cs_nxt        = reset_state();
        cs_nxt.sw_rst = 1'b1;
      end
      else if (ir == `MID_OP_OPTION)
        cs_nxt.option = cs_r.w;
      else if (ir == `MID_OP_STANDBY)
      begin
        cs_nxt.st                = MID_ST_STANDBY;
        cs_nxt.pc                = cs_r.pc;
        cs_nxt.wdt_clr           = 1'b1;
        cs_nxt.fl.timeout_flag   = 1'b1;
        cs_nxt.fl.powerdown_flag = 1'b0;
      end
      else if (ir == `MID_OP_WD_CLEAR)
      begin
        cs_nxt.wdt_clr           = 1'b1;
        cs_nxt.fl.timeout_flag   = 1'b1;
        cs_nxt.fl.powerdown_flag = 1'b1;
      end
      else if (dec_dir_load)
        cs_nxt.dir[ir[2:0]] = cs_r.w;
      else if (dec_ptr_add)
        cs_nxt.ptr[psel] = ptr_plus_k;
      else if (dec_ld_mod || dec_ld_idx)
      begin
        dmem.addr        = eff_addr;
        cs_nxt.w         = dmem_rdata;
        cs_nxt.fl.zero   = (dmem_rdata == 8'h00);
        cs_nxt.ptr[psel] = ptr_new;
      end
      else if (dec_st_mod || dec_st_idx)
      begin
        dmem.addr        = eff_addr;
        dmem.wdata       = cs_r.w;
        dmem.we          = 1'b1;
        cs_nxt.ptr[psel] = ptr_new;
      end
      else if (dec_rot)
      begin
        dmem.addr       = {{(`MID_PTR_W-7){1'b0}}, ir[6:0]};
        cs_nxt.fl.carry = dmem_rdata[0];
        if (ir[`MID_F_DEST])
        begin
          dmem.wdata = rot_res;
          dmem.we    = 1'b1;
        end
        else
          cs_nxt.w = rot_res;
      end
      // all-zero and unknown opcodes fall through as no-operation
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      cs_r <= reset_state();
    else
      cs_r <= cs_nxt;
  end

  // ****************************************************************************
  // outputs
  // ****************************************************************************
  assign prog_addr  = cs_r.pc;
  assign osc_stop   = (cs_r.st == MID_ST_STANDBY);
  assign wdt_clear  = cs_r.wdt_clr;
  assign soft_reset = cs_r.sw_rst;
  assign acc        = cs_r.w;
  assign flags      = cs_r.fl;
  assign option_reg = cs_r.option;
  assign pin_dir    = cs_r.dir;
  assign int_enable = cs_r.gie;

endmodule

`default_nettype wire

/* mid_core_monitor.sv */
`timescale 1ns/1ns
`default_nettype none
`include "mid_map.svh"

module mid_core_monitor
  import mid_pkg::*;
#(
  parameter int DIR_REGS = 8
)(
  // clock and reset
  input wire logic                     clk,
  input wire logic                     srst,
  // memories
  input wire logic [`MID_PC_W-1:0]     prog_addr,
  input wire logic [`MID_INSTR_W-1:0]  prog_data,
  input wire mid_dmem_s                dmem,
  input wire logic [7:0]               dmem_rdata,
  // control and state
  input wire logic                     wake,
  input wire logic                     osc_stop,
  input wire logic                     wdt_clear,
  input wire logic                     soft_reset,
  input wire logic [7:0]               acc,
  input wire mid_flags_s               flags,
  input wire logic [7:0]               option_reg,
  input wire logic [DIR_REGS-1:0][7:0] pin_dir,
  input wire logic                     int_enable,
  input wire logic                     stack_overflow,
  input wire logic                     stack_underflow
);
  // ********************
  // decode tracking
  // ********************
  logic                 flush_r;
  logic                 ind_r;
  logic [`MID_PC_W-1:0] addr_r;
  logic                 exec;
  logic                 two;
  logic                 ind;

  // no decode in flush, standby or extra access cycle
  assign exec = !srst && !osc_stop && !flush_r && !(ind_r && prog_addr == addr_r);
  assign two  = prog_data inside {14'h0008, 14'h0009, 14'h000A, 14'h000B} || prog_data[13:8] == 6'h34;
  assign ind  = prog_data[13:4] == 10'h001 || prog_data[13:8] == 6'h3F;

  always_ff @(posedge clk)
  begin
    flush_r <= !srst && exec && two;
    ind_r   <= !srst && exec && ind;
    addr_r  <= prog_addr;
  end

  // ********************
  // properties
  // ********************
  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_jump(logic [`MID_PC_W-1:0] t);
    prog_addr == t ##1 $stable(prog_addr);
  endsequence

  AST_BRANCH_ACC: assert property (exec && prog_data == 14'h000B |=> s_jump($past(prog_addr) + 15'h0001 + $past(acc)))
    else $error("branch target or length wrong");
  AST_CALL_ACC: assert property (exec && prog_data == 14'h000A |=> s_jump({$past(prog_addr[14:8]), $past(acc)}))
    else $error("call target or length wrong");
  AST_RETURN_LIT: assert property (exec && prog_data[13:8] == 6'h34 |=> acc == $past(prog_data[7:0]) ##1 $stable(prog_addr))
    else $error("literal return wrong");
  AST_RETURN_FLAGS: assert property (exec && prog_data == 14'h0008 |=> $stable(flags) ##1 $stable(prog_addr))
    else $error("return changed flags or length");
  AST_OPTION_LOAD: assert property (exec && prog_data == 14'h0062 |=> option_reg == $past(acc) && prog_addr == $past(prog_addr) + 15'h0001)
    else $error("option load wrong");
  AST_STANDBY: assert property (exec && prog_data == 14'h0063 |=> osc_stop && wdt_clear && flags.timeout_flag && !flags.powerdown_flag)
    else $error("standby entry wrong");
  AST_WD_CLEAR: assert property (exec && prog_data == 14'h0064 |=> wdt_clear && flags.timeout_flag && flags.powerdown_flag)
    else $error("watchdog clear wrong");
  AST_DIR_LOAD: assert property (exec && prog_data[13:3] == 11'h00C && !(prog_data[2:0] inside {3'h2, 3'h3, 3'h4}) |=> pin_dir[$past(prog_data[2:0])] == $past(acc))
    else $error("direction load wrong");
  AST_ROTATE: assert property (exec && prog_data[13:7] == 7'h19 |-> dmem.we && dmem.addr == 16'(prog_data[6:0]) && dmem.wdata == {flags.carry, dmem_rdata[7:1]} ##1 flags.carry == $past(dmem_rdata[0]))
    else $error("rotate wrong");
  AST_SOFT_RESET: assert property (exec && prog_data == 14'h0001 |=> soft_reset && prog_addr == 15'h0000 && acc == 8'h00)
    else $error("soft reset wrong");
endmodule

bind mid_core mid_core_monitor #(.DIR_REGS(DIR_REGS)) u_mid_core_monitor (
  .clk, .srst, .prog_addr, .prog_data, .dmem, .dmem_rdata, .wake, .osc_stop, .wdt_clear, .soft_reset,
  .acc, .flags, .option_reg, .pin_dir, .int_enable, .stack_overflow, .stack_underflow);

`default_nettype wire

/* mid_mem_model.sv */
`timescale 1ns/1ns
`default_nettype none
`include "mid_map.svh"

module mid_mem_model
  import mid_pkg::*;
(
  // clock
  input wire logic                    clk,
  // program side
  input wire logic [`MID_PC_W-1:0]    prog_addr,
  output logic     [`MID_INSTR_W-1:0] prog_data,
  // data side
  input wire mid_dmem_s               dmem,
  output logic     [7:0]              dmem_rdata
);
  logic [13:0] rom [0:255];
  logic [7:0]  ram [0:1023];

  // upper program space reads as no-operation
  assign prog_data  = prog_addr[14:8] == 7'h00 ? rom[prog_addr[7:0]] : 14'h0000;
  assign dmem_rdata = ram[dmem.addr[9:0]];

  always @(posedge clk)
  begin
    if (dmem.we)
    begin
      ram[dmem.addr[9:0]] <= dmem.wdata;
    end
  end
endmodule

`default_nettype wire

/* tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
`include "mid_map.svh"

module tb_top
  import mid_pkg::*;
;
  logic                    clk;
  logic                    srst;
  logic                    wake;
  logic [`MID_PC_W-1:0]    prog_addr;
  logic [`MID_INSTR_W-1:0] prog_data;
  mid_dmem_s               dmem;
  logic [7:0]              dmem_rdata;
  logic                    osc_stop;
  logic                    wdt_clear;
  logic                    soft_reset;
  logic [7:0]              acc;
  mid_flags_s              flags;
  logic [7:0]              option_reg;
  logic [7:0][7:0]         pin_dir;
  logic                    int_enable;
  logic                    stack_overflow;
  logic                    stack_underflow;
  int                      miscompares;
  int                      compares;
  int                      cyc;

  mid_core u_mid_core (.clk, .srst, .prog_addr, .prog_data, .dmem, .dmem_rdata, .wake, .osc_stop, .wdt_clear,
    .soft_reset, .acc, .flags, .option_reg, .pin_dir, .int_enable, .stack_overflow, .stack_underflow);
  mid_mem_model u_mid_mem_model (.clk, .prog_addr, .prog_data, .dmem, .dmem_rdata);

  always #4 clk = ~clk;

  // ********************
  // common tasks
  // ********************
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic setup(input logic [13:0] p [$]);
    for (int i = 0; i < 256; i++) u_mid_mem_model.rom[i] = 14'h0000;
    foreach (p[i]) u_mid_mem_model.rom[i] = p[i];
    srst = 1'b1;
    step(2);
    srst = 1'b0;
  endtask

  task automatic end_sim;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
    begin
      $display("TB: PASS");
    end
    else
    begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ********************
  // scenarios
  // ********************
  task automatic t_flow;
    u_mid_mem_model.ram[0] = 8'h03;
    u_mid_mem_model.ram[1] = 8'h09;
    setup('{14'h0012, 14'h000B, 14'h0000, 14'h0008, 14'h0000, 14'h000A, 14'h0012, 14'h000A, 14'h0009, 14'h3477});
    step(2);
    chk(16'(prog_addr), 16'h0005);
    step(2);
    chk(16'(prog_addr), 16'h0003);
    step(2);
    chk(16'(prog_addr), 16'h0006);
    step(2);
    chk({acc, 1'b0, prog_addr[6:0]}, 16'h0907);
    step(3);
    chk({acc, 1'b0, prog_addr[6:0]}, 16'h7708);
    step(2);
    chk({int_enable, stack_underflow, prog_addr[13:0]}, 16'hC000);
    $display("flow test done");
  endtask

  task automatic t_inherent;
    u_mid_mem_model.ram[0] = 8'h03;
    setup('{14'h0012, 14'h0062, 14'h0060, 14'h0061, 14'h0065, 14'h0066, 14'h0067, 14'h0063, 14'h0064});
    step(2);
    chk(16'(option_reg), 16'h0003);
    step(5);
    for (int i = 0; i < 8; i++) chk(16'(pin_dir[i]), (i inside {2, 3, 4}) ? 16'h00FF : 16'h0003);
    step(1);
    chk(16'({osc_stop, wdt_clear, flags.timeout_flag, flags.powerdown_flag}), 16'h000E);
    step(2);
    wake = 1'b1;
    step(1);
    wake = 1'b0;
    chk({osc_stop, prog_addr}, 16'h0008);
    step(1);
    chk({wdt_clear, flags.timeout_flag, flags.powerdown_flag, prog_addr[12:0]}, 16'hE009);
    $display("inherent test done");
  endtask

  task automatic t_indirect;
    u_mid_mem_model.ram[0]    = 8'h03;
    u_mid_mem_model.ram[2]    = 8'h00;
    u_mid_mem_model.ram[6]    = 8'h00;
    u_mid_mem_model.ram[1023] = 8'h00;
    setup('{14'h317F, 14'h0012, 14'h001E, 14'h3F85, 14'h3F42, 14'h0011});
    step(2);
    chk(16'(acc), 16'h0003);
    step(1);
    chk(16'(prog_addr), 16'h0002);
    step(1);
    chk({u_mid_mem_model.ram[1023], prog_addr[7:0]}, 16'h0303);
    step(1);
    chk(16'(u_mid_mem_model.ram[6]), 16'h0003);
    step(1);
    chk({acc, 7'h00, flags.zero}, 16'h0001);
    step(1);
    chk({acc, 7'h00, flags.zero}, 16'h0300);
    $display("indirect test done");
  endtask

  task automatic t_rotate;
    u_mid_mem_model.ram[5] = 8'h81;
    setup('{14'h0C85, 14'h0C05, 14'h0001});
    step(1);
    chk({u_mid_mem_model.ram[5], 7'h00, flags.carry}, 16'h4001);
    step(1);
    chk({acc, u_mid_mem_model.ram[5]}, 16'hA040);
    chk(16'(flags.carry), 16'h0000);
    step(1);
    chk({soft_reset, prog_addr}, 16'h8000);
    chk(16'(acc), 16'h0000);
    $display("rotate test done");
  endtask

  task automatic t_overflow;
    setup('{14'h000A});
    step(32);
    chk({15'h0000, stack_overflow}, 16'h0000);
    step(2);
    chk({15'h0000, stack_overflow}, 16'h0001);
    $display("overflow test done");
  endtask

  // ********************
  // run control
  // ********************
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 1000)
    begin
      miscompares++;
      end_sim();
    end
  end

  initial
  begin
    clk         = 1'b0;
    srst        = 1'b1;
    wake        = 1'b0;
    compares    = 0;
    miscompares = 0;
    cyc         = 0;
    step(20);
    t_flow();
    t_inherent();
    t_indirect();
    t_rotate();
    t_overflow();
    end_sim();
  end
endmodule

`default_nettype wire
